// >>> tcl_pkg.sv
// Shared types and constants for the traffic channel test loop
package tcl_pkg;

    localparam int          PAY_W      = 260;    // Widest looped frame
    localparam int          BURST_W    = 114;    // Information bits of one burst
    localparam int          FIFO_DEPTH = 16;
    localparam logic [8:0]  LEN_SPEECH = 9'h104; // 260 bits
    localparam logic [8:0]  LEN_EFR    = 9'h0F4; // 244 bits
    localparam logic [8:0]  LEN_BURST  = 9'h072; // 114 bits
    localparam logic [2:0]  SAPI_CMD   = 3'h0;   // Link layer access point of commands
    localparam logic [1:0]  SID_ERASED = 2'h0;
    localparam logic [1:0]  SID_BAD    = 2'h1;
    localparam logic [1:0]  SID_VALID  = 2'h2;
    localparam logic [1:0]  SID_NONE   = 2'h3;   // Plain speech or data frame

    typedef enum logic [6:0] {
        LOOP_NONE = 7'h01,
        LOOP_A    = 7'h02,
        LOOP_B    = 7'h04,
        LOOP_C    = 7'h08,
        LOOP_D    = 7'h10,
        LOOP_E    = 7'h20,
        LOOP_F    = 7'h40
    } tcl_loop_t;

    typedef enum logic [1:0] {
        OP_CLOSE = 2'h1,
        OP_OPEN  = 2'h2
    } tcl_op_t;

    typedef enum logic [3:0] {
        CH_FULL = 4'h1,
        CH_HALF = 4'h2,
        CH_EFR  = 4'h4,
        CH_DATA = 4'h8
    } tcl_chan_t;

    typedef enum logic [2:0] {
        BK_TRAFFIC = 3'h1,
        BK_SLOW_ASSOCIATED_CONTROL_CHANNEL   = 3'h2,
        BK_IDLE    = 3'h4
    } tcl_bkind_t;

    typedef struct packed {
        tcl_op_t    op;
        tcl_loop_t  loop;
        tcl_chan_t  chan;
        logic       on_dedicated_control_channel;
        logic [2:0] sapi;
        logic       ack_mode;
    } tcl_cmd_t;

    typedef struct packed {
        tcl_chan_t        chan;
        logic             bfi;
        logic             ufi;
        logic [1:0]       silence_descriptor;
        logic             facch;
        logic [8:0]       len;
        logic [PAY_W-1:0] bits;
    } tcl_frame_t;

    typedef struct packed {
        tcl_bkind_t         kind;
        logic               midamble_ok;
        logic [BURST_W-1:0] bits;
    } tcl_burst_t;

    typedef struct packed {
        logic             is_burst;
        logic             own_midamble;
        logic [8:0]       len;
        logic [PAY_W-1:0] bits;
    } tcl_ul_t;

    localparam int UL_W = $bits(tcl_ul_t);

    typedef struct packed {
        logic [2:0] sim_s;
        logic [2:0] pwr_s;
        logic       sim_ok;
        logic       pwr_ok;
        tcl_loop_t  loop;
        tcl_chan_t  chan;
        logic       ack;
        logic       ign;
    } tcl_top_st_t;

    localparam tcl_top_st_t TOP_RESET = '{sim_s: 3'h0, pwr_s: 3'h0, sim_ok: 1'b0,
        pwr_ok: 1'b0, loop: LOOP_NONE, chan: CH_FULL, ack: 1'b0, ign: 1'b0};

endpackage : tcl_pkg

// >>> tcl_loop.sv
// Uplink FIFO and the traffic channel test loop logic
`timescale 1ns/1ns

// What this block does
// RULE_01 - Loops are closed and opened only by commands from the simulator.
// RULE_02 - Commands count only if carried on the control channel, access point 0, acknowledged.
// RULE_03 - Power-off or test card removal drops any active loop.
// RULE_04 - No loop closes while the digital audio test runs; each locks out the other.
// RULE_05 - Test functions work only while a test card is present.
// RULE_06 - Normal receive processing continues while a loop runs.
// RULE_07 - A loop closes only while a traffic channel is active.
// RULE_08 - Full, half and enhanced rate speech and data channels can all be looped.
// RULE_09 - Six loop types A to F are selectable.
// RULE_10 - Loop A zeroes erased frames, speech or data.
// RULE_11 - Loop C sends the 114 decrypted burst bits uplink, without stealing flags.
// RULE_12 - Loop C re-sends every traffic burst whatever its midamble looked like.
// RULE_13 - Loop C bursts use the mobile's own midamble.
// RULE_14 - Loop C never loops control or idle bursts.
// RULE_15 - Loops A and B send 244 bits per enhanced rate frame.
// RULE_16 - Loop D zeroes erased and unreliable half rate frames.
// RULE_17 - Loop E zeroes erased silence descriptor frames.
// RULE_18 - Loop F zeroes erased valid silence descriptor frames.
// RULE_19 - A close command is ignored without traffic channel or with a loop closed.
// RULE_20 - Bad frames are signalled by an all-zero frame to the encoder.
// RULE_21 - Loops A and B send 260 bits per full or half rate speech frame.
// RULE_22 - One register holds the active loop until opened, power-off or card removal.

module tcl_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         mclk_i,
    input  wire logic         resetn_i,
    input  wire logic         ce_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wr;
        logic [AW:0]             rd;
    } tcl_fifo_st_t;

    tcl_fifo_st_t st;
    tcl_fifo_st_t next_st;
    logic [AW:0]  fill;

    // Extra pointer bit tells full from empty
    assign fill        = st.wr - st.rd;
    assign in_ready_o  = ce_i && (fill != (AW+1)'(DEPTH));
    assign out_valid_o = ce_i && (fill != '0);
    assign out_data_o  = st.mem[st.rd[AW-1:0]];

    // Push and pop are independent, so a full FIFO still drains and refills
    always_comb begin
        next_st = st;
        if (in_valid_i && in_ready_o) begin
            next_st.mem[st.wr[AW-1:0]] = in_data_i;
            next_st.wr                 = st.wr + 1'b1;
        end
        if (out_valid_o && out_ready_i) begin
            next_st.rd = st.rd + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end
endmodule : tcl_fifo

module tcl_loop (
    input  wire logic                 mclk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 ce_i,
    input  wire logic                 test_sim_i,
    input  wire logic                 power_on_i,
    input  wire logic                 tch_active_i,
    input  wire logic                 dai_active_i,
    input  wire logic                 cmd_valid_i,
    input  wire tcl_pkg::tcl_cmd_t    cmd_i,
    input  wire logic                 frame_valid_i,
    input  wire tcl_pkg::tcl_frame_t  frame_i,
    output logic                      frame_ready_o,
    input  wire logic                 burst_valid_i,
    input  wire tcl_pkg::tcl_burst_t  burst_i,
    output logic                      burst_ready_o,
    output logic                      ul_valid_o,
    input  wire logic                 ul_ready_i,
    output tcl_pkg::tcl_ul_t          ul_data_o,
    output logic                      test_enabled_o,
    output logic                      loop_active_o,
    output tcl_pkg::tcl_loop_t        loop_type_o,
    output logic                      dai_permit_o,
    output logic                      cmd_ack_o,
    output logic                      cmd_ignored_o
);
    tcl_pkg::tcl_top_st_t st;
    tcl_pkg::tcl_top_st_t next_st;
    tcl_pkg::tcl_ul_t     word;
    logic                 enabled;
    logic                 cmd_ok;
    logic                 burst_take;
    logic                 frame_take;
    logic                 frame_keep;
    logic                 frame_zero;
    logic                 fifo_ready;
    logic                 push;
    logic [8:0]           frame_len;

    assign enabled        = st.sim_ok && st.pwr_ok;
    assign test_enabled_o = enabled;
    assign loop_active_o  = (st.loop != tcl_pkg::LOOP_NONE);
    assign loop_type_o    = st.loop;
    assign dai_permit_o   = !loop_active_o; // RULE_04
    assign cmd_ack_o      = st.ack;
    assign cmd_ignored_o  = st.ign;

    // Only commands from the simulator's signalling link may steer the loop
    assign cmd_ok = cmd_valid_i && cmd_i.on_dedicated_control_channel && cmd_i.ack_mode // RULE_01
                 && (cmd_i.sapi == tcl_pkg::SAPI_CMD); // RULE_02

    // Control state: synchronisers, the loop register and command answers
    always_comb begin
        next_st     = st;
        next_st.ack = 1'b0;
        next_st.ign = 1'b0;
        // Stage 0 feeds stage 1 only; the level moves once stages 1 and 2 agree
        next_st.sim_s = {st.sim_s[1:0], test_sim_i};
        next_st.pwr_s = {st.pwr_s[1:0], power_on_i};
        if (st.sim_s[1] == st.sim_s[2]) begin
            next_st.sim_ok = st.sim_s[2];
        end
        if (st.pwr_s[1] == st.pwr_s[2]) begin
            next_st.pwr_ok = st.pwr_s[2];
        end
        if (!enabled) begin
            next_st.loop = tcl_pkg::LOOP_NONE; // RULE_03 RULE_05
        end else if (cmd_ok) begin
            unique case (cmd_i.op)
                tcl_pkg::OP_CLOSE: begin
                    // A close for no loop type at all is treated as malformed
                    if (tch_active_i && !loop_active_o && !dai_active_i // RULE_07 RULE_19 RULE_04
                        && (cmd_i.loop != tcl_pkg::LOOP_NONE)) begin
                        next_st.loop = cmd_i.loop; // RULE_09 RULE_22
                        next_st.chan = cmd_i.chan; // RULE_08
                        next_st.ack  = 1'b1;
                    end else begin
                        next_st.ign = 1'b1; // RULE_19
                    end
                end
                tcl_pkg::OP_OPEN: begin
                    next_st.loop = tcl_pkg::LOOP_NONE; // RULE_22
                end
                default: begin
                    next_st.ign = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= tcl_pkg::TOP_RESET;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // Per-loop frame treatment; FACCH frames in A and B have no defined
    // response, so they are simply not looped
    always_comb begin
        frame_keep = 1'b0;
        frame_zero = 1'b0;
        unique case (st.loop)
            tcl_pkg::LOOP_NONE, tcl_pkg::LOOP_C: begin
                frame_keep = 1'b0;
            end
            tcl_pkg::LOOP_A: begin
                frame_keep = !frame_i.facch;
                frame_zero = frame_i.bfi; // RULE_10 RULE_20
            end
            tcl_pkg::LOOP_B: begin
                frame_keep = !frame_i.facch && (frame_i.chan != tcl_pkg::CH_DATA);
            end
            tcl_pkg::LOOP_D: begin
                frame_keep = 1'b1;
                frame_zero = frame_i.bfi || frame_i.ufi || frame_i.facch; // RULE_16
            end
            tcl_pkg::LOOP_E: begin
                frame_keep = 1'b1;
                frame_zero = (frame_i.silence_descriptor == tcl_pkg::SID_ERASED) || frame_i.facch; // RULE_17
            end
            tcl_pkg::LOOP_F: begin
                frame_keep = 1'b1;
                frame_zero = (frame_i.bfi && (frame_i.silence_descriptor != tcl_pkg::SID_NONE)) // RULE_18
                          || frame_i.facch;
            end
        endcase
    end

    // Enhanced rate speech is shorter; data frames carry their own length
    always_comb begin
        unique case (frame_i.chan)
            tcl_pkg::CH_EFR:  frame_len = tcl_pkg::LEN_EFR; // RULE_15
            tcl_pkg::CH_DATA: frame_len = frame_i.len;
            default:          frame_len = tcl_pkg::LEN_SPEECH; // RULE_21
        endcase
    end

    // Midamble quality is deliberately not looked at
    assign burst_take = (st.loop == tcl_pkg::LOOP_C) && burst_valid_i // RULE_12
                     && (burst_i.kind == tcl_pkg::BK_TRAFFIC); // RULE_14
    assign frame_take = frame_valid_i && frame_keep && (frame_i.chan == st.chan);
    assign push       = burst_take || frame_take;

    // Build the uplink word for whichever path is feeding the encoder
    always_comb begin
        word = '0;
        if (burst_take) begin
            word.is_burst            = 1'b1;
            word.own_midamble        = 1'b1; // RULE_13
            word.len                 = tcl_pkg::LEN_BURST;
            word.bits[tcl_pkg::BURST_W-1:0] = burst_i.bits; // RULE_11
        end else if (frame_take) begin
            word.len  = frame_len;
            word.bits = frame_zero ? '0 : frame_i.bits; // RULE_20
        end
    end

    // Unlooped traffic is always taken so normal decoding never stalls;
    // looped traffic waits for room in the uplink FIFO
    assign frame_ready_o = frame_take ? fifo_ready : ce_i; // RULE_06
    assign burst_ready_o = burst_take ? fifo_ready : ce_i; // RULE_06

    tcl_fifo #(
        .W     (tcl_pkg::UL_W),
        .DEPTH (tcl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .resetn_i    (resetn_i),
        .ce_i        (ce_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (word),
        .out_valid_o (ul_valid_o),
        .out_ready_i (ul_ready_i),
        .out_data_o  (ul_data_o)
    );

    // Checks on the design's own behaviour
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    property p_power_off;
        (ce_i && !st.pwr_ok) |=> !loop_active_o;
    endproperty
    a_power_off: assert property (p_power_off) else $error("loop kept after power-off"); // RULE_03

    property p_no_sim;
        (ce_i && !enabled) |=> !loop_active_o && !cmd_ack_o;
    endproperty
    a_no_sim: assert property (p_no_sim) else $error("test active without test card"); // RULE_05

    property p_dai_lock;
        (ce_i && enabled && cmd_ok && cmd_i.op == tcl_pkg::OP_CLOSE && dai_active_i)
            |=> cmd_ignored_o && !cmd_ack_o;
    endproperty
    a_dai_lock: assert property (p_dai_lock) else $error("loop closed in audio test"); // RULE_04

    property p_no_tch;
        (ce_i && enabled && cmd_ok && cmd_i.op == tcl_pkg::OP_CLOSE && !tch_active_i)
            |=> cmd_ignored_o && !cmd_ack_o;
    endproperty
    a_no_tch: assert property (p_no_tch) else $error("loop closed without traffic"); // RULE_07

    property p_already;
        (ce_i && enabled && cmd_ok && cmd_i.op == tcl_pkg::OP_CLOSE && loop_active_o)
            |=> cmd_ignored_o && $stable(loop_type_o);
    endproperty
    a_already: assert property (p_already) else $error("second close not ignored"); // RULE_19

    property p_ack_loop;
        $rose(cmd_ack_o) |-> loop_active_o && (loop_type_o == $past(cmd_i.loop));
    endproperty
    a_ack_loop: assert property (p_ack_loop) else $error("loop register wrong on ack"); // RULE_22

    property p_burst_word;
        (push && burst_take) |-> word.len == tcl_pkg::LEN_BURST && word.is_burst;
    endproperty
    a_burst_word: assert property (p_burst_word) else $error("burst length not 114"); // RULE_11

    property p_own_mid;
        (push && burst_take) |-> word.own_midamble;
    endproperty
    a_own_mid: assert property (p_own_mid) else $error("burst without own midamble"); // RULE_13

    property p_no_ctrl;
        (st.loop == tcl_pkg::LOOP_C && burst_valid_i && burst_i.kind != tcl_pkg::BK_TRAFFIC)
            |-> !push;
    endproperty
    a_no_ctrl: assert property (p_no_ctrl) else $error("control burst looped"); // RULE_14

    property p_erase;
        (frame_take && st.loop == tcl_pkg::LOOP_A && frame_i.bfi) |-> word.bits == '0;
    endproperty
    a_erase: assert property (p_erase) else $error("erased frame not zeroed"); // RULE_20

    property p_efr;
        (frame_take && frame_i.chan == tcl_pkg::CH_EFR) |-> word.len == tcl_pkg::LEN_EFR;
    endproperty
    a_efr: assert property (p_efr) else $error("enhanced rate length not 244"); // RULE_15

    // Half rate zeroing and plain speech length
    property p_unreliable;
        (frame_take && st.loop == tcl_pkg::LOOP_D && frame_i.ufi) |-> word.bits == '0;
    endproperty
    a_unreliable: assert property (p_unreliable) else $error("unreliable frame kept"); // RULE_16

    property p_speech_len;
        (frame_take && frame_i.chan inside {tcl_pkg::CH_FULL, tcl_pkg::CH_HALF})
            |-> word.len == tcl_pkg::LEN_SPEECH;
    endproperty
    a_speech_len: assert property (p_speech_len) else $error("speech length not 260"); // RULE_21

    // Main scenarios a run should reach
    c_burst: cover property (push && burst_take && fifo_ready);
    c_zero:  cover property (frame_take && frame_zero && fifo_ready);
    c_full:  cover property (loop_active_o && !fifo_ready && ce_i);
    c_ack:   cover property (cmd_ack_o);
    c_ign:   cover property (cmd_ignored_o);
endmodule : tcl_loop

// >>> tcl_sim_model.sv
// Simulator-side sink that takes looped uplink words off the test loop
`timescale 1ns/1ns
module tcl_sim_model (
    input  wire logic             mclk_i,
    input  wire logic             resetn_i,
    input  wire logic             stall_i,
    input  wire logic             ul_valid_i,
    input  wire tcl_pkg::tcl_ul_t ul_data_i,
    output logic                  ul_ready_o
);
    tcl_pkg::tcl_ul_t got[$];
    logic [7:0]       lfsr;

    // Ready wanders so the FIFO sees both prompt and slow takers
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ul_ready_o <= 1'b0;
            lfsr       <= 8'h5B;
        end else begin
            if (ul_valid_i && ul_ready_o) begin
                got.push_back(ul_data_i);
            end
            lfsr       <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            ul_ready_o <= !stall_i && (lfsr[1:0] != 2'h0);
        end
    end
endmodule : tcl_sim_model

// >>> traffic_channel_test_loop_tb_top.sv
// Self-checking bench for the traffic channel test loop
`timescale 1ns/1ns
module traffic_channel_test_loop_tb_top;
    localparam int PW = tcl_pkg::PAY_W;
    logic mclk_i = 1'b0, resetn_i = 1'b0, test_sim_i = 1'b0, power_on_i = 1'b1;
    logic tch_active_i = 1'b0, dai_active_i = 1'b0, cmd_valid_i = 1'b0, stall = 1'b0;
    logic frame_valid_i = 1'b0, burst_valid_i = 1'b0, frame_ready_o, burst_ready_o;
    logic ul_valid_o, ul_ready_i, test_enabled_o, loop_active_o, dai_permit_o;
    logic cmd_ack_o, cmd_ignored_o;
    tcl_pkg::tcl_cmd_t   cmd_i = '0;
    tcl_pkg::tcl_frame_t frame_i = '0;
    tcl_pkg::tcl_burst_t burst_i = '0;
    tcl_pkg::tcl_ul_t    ul_data_o;
    tcl_pkg::tcl_loop_t  loop_type_o;
    int errors = 0, n_compared = 0, cyc = 0;
    logic [31:0] seed = 32'h09490D19;

    tcl_loop i_tcl_loop (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(1'b1),
        .test_sim_i(test_sim_i), .power_on_i(power_on_i), .tch_active_i(tch_active_i),
        .dai_active_i(dai_active_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .frame_valid_i(frame_valid_i), .frame_i(frame_i), .frame_ready_o(frame_ready_o),
        .burst_valid_i(burst_valid_i), .burst_i(burst_i), .burst_ready_o(burst_ready_o),
        .ul_valid_o(ul_valid_o), .ul_ready_i(ul_ready_i), .ul_data_o(ul_data_o),
        .test_enabled_o(test_enabled_o), .loop_active_o(loop_active_o),
        .loop_type_o(loop_type_o), .dai_permit_o(dai_permit_o), .cmd_ack_o(cmd_ack_o),
        .cmd_ignored_o(cmd_ignored_o));
    tcl_sim_model i_tcl_sim_model (.mclk_i(mclk_i), .resetn_i(resetn_i), .stall_i(stall),
        .ul_valid_i(ul_valid_o), .ul_data_i(ul_data_o), .ul_ready_o(ul_ready_i));

    always #4 mclk_i = ~mclk_i;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            $display("ERROR timeout expected finished seen running");
            results();
        end
    end

    task automatic chk1(string nm, logic e, logic g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic chkv(string nm, logic [PW-1:0] e, logic [PW-1:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chkv

    // Command strobe for one cycle; returns in the cycle the answer stands
    task automatic cmd(tcl_pkg::tcl_op_t op, tcl_pkg::tcl_loop_t lp, tcl_pkg::tcl_chan_t ch,
                       logic [2:0] sapi);
        @(negedge mclk_i);
        cmd_valid_i = 1'b1;
        cmd_i = '{op: op, loop: lp, chan: ch, on_dedicated_control_channel: 1'b1, sapi: sapi, ack_mode: 1'b1};
        @(negedge mclk_i);
        cmd_valid_i = 1'b0;
    endtask : cmd

    task automatic close(tcl_pkg::tcl_loop_t lp, tcl_pkg::tcl_chan_t ch, logic ea, logic ei);
        cmd(tcl_pkg::OP_CLOSE, lp, ch, tcl_pkg::SAPI_CMD);
        chk1("cmd_ack", ea, cmd_ack_o);
        chk1("cmd_ignored", ei, cmd_ignored_o);
    endtask : close

    // Holds valid until the edge that takes the item; caller lowers it
    task automatic push(logic isb, tcl_pkg::tcl_frame_t f, tcl_pkg::tcl_burst_t b);
        int n;
        frame_valid_i = !isb;
        frame_i = f;
        burst_valid_i = isb;
        burst_i = b;
        n = 0;
        #1;
        while (!(isb ? burst_ready_o : frame_ready_o) && n < 200) begin
            @(negedge mclk_i);
            n++;
        end
        chk1("ready", 1'b1, isb ? burst_ready_o : frame_ready_o);
        @(negedge mclk_i);
    endtask : push

    task automatic idle();
        frame_valid_i = 1'b0;
        burst_valid_i = 1'b0;
        @(negedge mclk_i);
    endtask : idle

    // Waits for one uplink word and compares the low wb bits of its payload
    task automatic expect_ul(logic lp, logic isb, logic [8:0] ln, logic [PW-1:0] e, int wb);
        int n;
        tcl_pkg::tcl_ul_t u;
        logic [PW-1:0] m;
        n = 0;
        m = (wb == 0) ? '0 : ({PW{1'b1}} >> (PW - wb));
        while (i_tcl_sim_model.got.size() == 0 && n < 40) begin
            @(negedge mclk_i);
            n++;
        end
        chk1("looped", lp, i_tcl_sim_model.got.size() != 0);
        if (i_tcl_sim_model.got.size() != 0) begin
            u = i_tcl_sim_model.got.pop_front();
            chk1("is_burst", isb, u.is_burst);
            if (isb) chk1("own_midamble", 1'b1, u.own_midamble);
            chkv("len", PW'(ln), PW'(u.len));
            chkv("bits", e & m, u.bits & m);
        end
    endtask : expect_ul

    // Expected treatment of one decoded frame under a closed loop
    function automatic void model_frame(tcl_pkg::tcl_loop_t lp, tcl_pkg::tcl_chan_t ch,
        tcl_pkg::tcl_frame_t f, output logic lpd, output logic z, output logic [8:0] ln);
        lpd = (f.chan == ch) && !(f.facch && lp inside {tcl_pkg::LOOP_A, tcl_pkg::LOOP_B})
              && !(lp == tcl_pkg::LOOP_B && f.chan == tcl_pkg::CH_DATA);
        case (lp)
            tcl_pkg::LOOP_A: z = f.bfi;
            tcl_pkg::LOOP_D: z = f.bfi | f.ufi | f.facch;
            tcl_pkg::LOOP_E: z = (f.silence_descriptor == tcl_pkg::SID_ERASED) | f.facch;
            tcl_pkg::LOOP_F: z = (f.bfi & (f.silence_descriptor != tcl_pkg::SID_NONE)) | f.facch;
            default: z = 1'b0;
        endcase
        ln = (f.chan == tcl_pkg::CH_EFR) ? tcl_pkg::LEN_EFR :
             (f.chan == tcl_pkg::CH_DATA) ? f.len : tcl_pkg::LEN_SPEECH;
    endfunction : model_frame

    initial begin
        tcl_pkg::tcl_loop_t  lps [5];
        tcl_pkg::tcl_loop_t  lp;
        tcl_pkg::tcl_chan_t  ch;
        tcl_pkg::tcl_frame_t f;
        tcl_pkg::tcl_burst_t b;
        tcl_pkg::tcl_burst_t q[$];
        logic                lpd, z;
        logic [8:0]          ln;
        logic [31:0]         r;
        lps = '{tcl_pkg::LOOP_A, tcl_pkg::LOOP_B, tcl_pkg::LOOP_D, tcl_pkg::LOOP_E,
                tcl_pkg::LOOP_F};
        f = '0;
        b = '0;
        repeat (12) @(negedge mclk_i);
        resetn_i = 1'b1;
        tch_active_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        // A network card keeps every test function dead
        chk1("test_enabled", 1'b0, test_enabled_o);
        close(tcl_pkg::LOOP_A, tcl_pkg::CH_FULL, 1'b0, 1'b0);
        test_sim_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        chk1("test_enabled", 1'b1, test_enabled_o);
        $display("test card gating done");
        // Refused and unanswered close commands, then an undefined command
        tch_active_i = 1'b0;
        close(tcl_pkg::LOOP_A, tcl_pkg::CH_FULL, 1'b0, 1'b1);
        tch_active_i = 1'b1;
        dai_active_i = 1'b1;
        close(tcl_pkg::LOOP_B, tcl_pkg::CH_FULL, 1'b0, 1'b1);
        dai_active_i = 1'b0;
        cmd(tcl_pkg::OP_CLOSE, tcl_pkg::LOOP_A, tcl_pkg::CH_FULL, 3'h1);
        chk1("cmd_ack", 1'b0, cmd_ack_o | cmd_ignored_o);
        close(tcl_pkg::LOOP_NONE, tcl_pkg::CH_FULL, 1'b0, 1'b1);
        cmd(tcl_pkg::tcl_op_t'(2'h3), tcl_pkg::LOOP_A, tcl_pkg::CH_FULL, tcl_pkg::SAPI_CMD);
        chk1("cmd_ignored", 1'b1, cmd_ignored_o);
        $display("refusal test done");
        // Burst loop: kinds, midamble, then fill the FIFO while the far side stalls
        close(tcl_pkg::LOOP_C, tcl_pkg::CH_FULL, 1'b1, 1'b0);
        chkv("loop_type", {253'h0, tcl_pkg::LOOP_C}, {253'h0, loop_type_o});
        chk1("dai_permit", 1'b0, dai_permit_o);
        close(tcl_pkg::LOOP_A, tcl_pkg::CH_FULL, 1'b0, 1'b1);
        for (int k = 0; k < 3; k++) begin
            b = '{kind: tcl_pkg::tcl_bkind_t'(3'h1 << k), midamble_ok: 1'b0,
                  bits: 114'({rnd(), rnd(), rnd(), rnd()})};
            push(1'b1, f, b);
            idle();
            expect_ul(k == 0, 1'b1, tcl_pkg::LEN_BURST, PW'(b.bits), 114);
        end
        stall = 1'b1;
        for (int i = 0; i < 17; i++) begin
            b = '{kind: tcl_pkg::BK_TRAFFIC, midamble_ok: rnd() > 32'h7FFFFFFF,
                  bits: 114'({rnd(), rnd(), rnd(), rnd()})};
            q.push_back(b);
            if (i == 16) begin
                burst_valid_i = 1'b1;
                burst_i = b;
                repeat (3) @(negedge mclk_i);
                chk1("burst_ready", 1'b0, burst_ready_o);
                stall = 1'b0;
            end
            push(1'b1, f, b);
        end
        idle();
        for (int i = 0; i < 17; i++) begin
            expect_ul(1'b1, 1'b1, tcl_pkg::LEN_BURST, PW'(q[i].bits), 114);
        end
        cmd(tcl_pkg::OP_OPEN, tcl_pkg::LOOP_C, tcl_pkg::CH_FULL, tcl_pkg::SAPI_CMD);
        chk1("loop_active", 1'b0, loop_active_o);
        chk1("dai_permit", 1'b1, dai_permit_o);
        frame_valid_i = 1'b1;
        @(negedge mclk_i);
        chk1("frame_ready", 1'b1, frame_ready_o);
        idle();
        $display("burst loop test done");
        // Random frame loops over every frame loop type and channel type
        for (int it = 0; it < 40; it++) begin
            lp = lps[rnd() % 5];
            ch = tcl_pkg::tcl_chan_t'(4'h1 << (it % 4));
            close(lp, ch, 1'b1, 1'b0);
            for (int j = 0; j < 4; j++) begin
                r = rnd();
                f.bits = PW'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
                f.chan = r[4] ? ch : tcl_pkg::tcl_chan_t'(4'h1 << r[6:5]);
                f.bfi = r[7];
                f.ufi = r[8];
                f.silence_descriptor = r[10:9];
                f.facch = (r[13:11] == 3'h0);
                f.len = {1'b0, r[21:14]};
                model_frame(lp, ch, f, lpd, z, ln);
                push(1'b0, f, b);
                idle();
                expect_ul(lpd, 1'b0, ln, z ? '0 : f.bits, z ? PW : ln);
            end
            cmd(tcl_pkg::OP_OPEN, lp, ch, tcl_pkg::SAPI_CMD);
        end
        $display("frame loop test done");
        // Power-off and card removal drop a closed loop
        close(tcl_pkg::LOOP_D, tcl_pkg::CH_HALF, 1'b1, 1'b0);
        power_on_i = 1'b0;
        repeat (8) @(negedge mclk_i);
        chk1("loop_active", 1'b0, loop_active_o);
        power_on_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        close(tcl_pkg::LOOP_E, tcl_pkg::CH_HALF, 1'b1, 1'b0);
        test_sim_i = 1'b0;
        repeat (8) @(negedge mclk_i);
        chk1("loop_active", 1'b0, loop_active_o);
        chk1("test_enabled", 1'b0, test_enabled_o);
        $display("power and card test done");
        results();
    end
endmodule : traffic_channel_test_loop_tb_top
